//--- ppd_defines.vh
// Purpose: constants for the parallel port pull-up and direction block
// Assumes: apb byte addresses, 32-bit data, one word per register
// Notes:   offsets are placed by the block's own choice
`ifndef PPD_DEFINES_VH
`define PPD_DEFINES_VH
// ----------------------------------------------------------------
// register offsets (paddr[7:0])
// ----------------------------------------------------------------
`define PPD_OFS_DIR_E      8'h00
`define PPD_OFS_LATCH_E    8'h04
`define PPD_OFS_LEVEL_E    8'h08
`define PPD_OFS_PULL_E     8'h0c
`define PPD_OFS_DIR_D      8'h10
`define PPD_OFS_PULL_D     8'h14
`define PPD_OFS_DIR_F      8'h18
`define PPD_OFS_CTRL       8'h1c
`define PPD_OFS_SEG        8'h20
// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define PPD_RST_BYTE       8'h00
`define PPD_DIR_F_RST_M46  8'h80
`define PPD_DIR_F_RST_M7   8'h00
`define PPD_DIR_F_MASK     8'hfd
`define PPD_F_CLK_BIT      7
`define PPD_UNDEF_WORD     32'hdeadbeef
`define PPD_ZERO_WORD      32'h00000000
`define PPD_MODE_7         3'h7
`define PPD_MODE_4         3'h4
`define PPD_MODE_6         3'h6
`define PPD_CTRL_RD_BIT    0
`define PPD_SEG_E_BIT      0
`define PPD_SEG_D_BIT      1
`endif

//--- ppd_pin_bit.v
// Purpose: one pin of a port: readback and pull-up gate
// Assumes: pin levels synchronous to the clock
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module ppd_pin_bit
(
  input  wire dir_in,      // 1 output, 0 input
  input  wire latch_in,    // output latch bit
  input  wire pin_in,      // sampled pin level
  input  wire pull_in,     // pull-up control bit
  input  wire gio_in,      // pin works as general i/o
  input  wire pull_ok_in,  // mode/bus/standby allow pull-ups
  input  wire seg_in,      // segment driver selected
  output wire read_out,    // pin-level readback
  output wire pull_out     // pull-up on
);
  // readback picks latch for outputs, pin for inputs
  assign read_out = dir_in ? latch_in : pin_in;
  // pull-up only for an input, enabled bit, no segment use
  assign pull_out = pull_ok_in & gio_in & ~dir_in & pull_in & ~seg_in;
endmodule // ppd_pin_bit
`default_nettype wire

//--- ppd_apb_dec.v
// Purpose: apb access decode for the port register file
// Assumes: zero wait state slave
// Notes:   write strobe lasts the access cycle only
`timescale 1ns/1ps
`default_nettype none
`include "ppd_defines.vh"
module ppd_apb_dec
(
  input  wire       psel_in,
  input  wire       penable_in,
  input  wire       pwrite_in,
  input  wire [7:0] paddr_in,
  output wire       wr_out,
  output wire       rd_out,
  output wire       setup_rd_out,
  output wire [7:0] addr_out
);
  // access strobes
  assign wr_out       = psel_in & penable_in & pwrite_in;
  assign rd_out       = psel_in & penable_in & ~pwrite_in;
  assign setup_rd_out = psel_in & ~penable_in & ~pwrite_in;
  assign addr_out     = paddr_in;
endmodule // ppd_apb_dec
`default_nettype wire

//--- ppd_port_top.v
// Purpose: port e/d pull-up and direction logic, port f direction
// Assumes: apb slave, no wait states, pins synchronous to sys_clk_in
// Notes:   mode, bus width and standby are straps and status inputs
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ppd_defines.vh"
module ppd_port_top
#(
  parameter WIDTH = 8
)
(
  // clock and reset
  input  wire             sys_clk_in,
  input  wire             arst_n_in,

  // apb slave side
  input  wire             psel_in,
  input  wire             penable_in,
  input  wire             pwrite_in,
  input  wire [7:0]       paddr_in,
  input  wire [31:0]      pwdata_in,
  output reg  [31:0]      prdata_out,
  output reg              pready_out,
  output reg              pslverr_out,

  // operating mode, bus width and standby straps
  input  wire [2:0]       mode_in,
  input  wire             bus16_in,
  input  wire             hw_standby_in,

  // pin levels and the bus and segment units
  input  wire [WIDTH-1:0] pin_e_in,
  input  wire [WIDTH-1:0] pin_d_in,
  input  wire [WIDTH-1:0] data_bus_out_in,
  input  wire             data_bus_oe_in,
  input  wire [WIDTH-1:0] seg_drive_in,
  input  wire             sys_clock_en_in,

  // registered pin controls
  output reg  [WIDTH-1:0] pin_e_out,
  output reg  [WIDTH-1:0] pin_e_oe_out,
  output reg  [WIDTH-1:0] pull_e_out,
  output reg  [WIDTH-1:0] pull_d_out,
  output reg  [WIDTH-1:0] low_data_byte_lines_out,
  output reg  [WIDTH-1:0] pin_dir_d_out,
  output reg  [7:0]       pin_dir_f_out,
  output reg              clock_out_pin_out,
  output reg              clock_out_oe_out
);
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire       wr;
  wire       setup_rd;
  wire [7:0] addr;
  ppd_apb_dec u_dec
  (
    .psel_in      (psel_in),
    .penable_in   (penable_in),
    .pwrite_in    (pwrite_in),
    .paddr_in     (paddr_in),
    .wr_out       (wr),
    .rd_out       (), // read data launches in the setup cycle
    .setup_rd_out (setup_rd),
    .addr_out     (addr)
  );
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [WIDTH-1:0] pin_direction_e_reg;
  reg  [WIDTH-1:0] output_latch_e_reg;
  reg  [WIDTH-1:0] pullup_control_e_reg;
  reg  [WIDTH-1:0] pin_direction_d_reg;
  reg  [WIDTH-1:0] pullup_control_d_reg;
  reg  [7:0]       pin_direction_f_reg;
  reg              seg_e_reg;
  reg              seg_d_reg;
  reg              f_init_reg;
  wire             mode7 = (mode_in == `PPD_MODE_7);
  wire             mode46 = (mode_in >= `PPD_MODE_4) &&
                            (mode_in <= `PPD_MODE_6);

  // port f direction: mode strap caught on the first edge after release
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pin_direction_f_reg <= `PPD_RST_BYTE;
      f_init_reg          <= 1'b0;
    end
    else if (!f_init_reg)
    begin
      f_init_reg          <= 1'b1;
      pin_direction_f_reg <= mode7 ? `PPD_DIR_F_RST_M7
                                   : `PPD_DIR_F_RST_M46;
    end
    else if (wr && addr == `PPD_OFS_DIR_F)
      pin_direction_f_reg <= pwdata_in[7:0] & `PPD_DIR_F_MASK;
  end

  // port e direction, written at the access edge
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      pin_direction_e_reg <= `PPD_RST_BYTE;
    else if (wr && addr == `PPD_OFS_DIR_E)
      pin_direction_e_reg <= pwdata_in[WIDTH-1:0];
  end

  // port e output latch
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      output_latch_e_reg <= `PPD_RST_BYTE;
    else if (wr && addr == `PPD_OFS_LATCH_E)
      output_latch_e_reg <= pwdata_in[WIDTH-1:0];
  end

  // port e pull-up control
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      pullup_control_e_reg <= `PPD_RST_BYTE;
    else if (wr && addr == `PPD_OFS_PULL_E)
      pullup_control_e_reg <= pwdata_in[WIDTH-1:0];
  end

  // port d direction
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      pin_direction_d_reg <= `PPD_RST_BYTE;
    else if (wr && addr == `PPD_OFS_DIR_D)
      pin_direction_d_reg <= pwdata_in[WIDTH-1:0];
  end

  // port d pull-up control
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      pullup_control_d_reg <= `PPD_RST_BYTE;
    else if (wr && addr == `PPD_OFS_PULL_D)
      pullup_control_d_reg <= pwdata_in[WIDTH-1:0];
  end

  // segment select for both ports
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      seg_e_reg <= 1'b0;
      seg_d_reg <= 1'b0;
    end
    else if (wr && addr == `PPD_OFS_SEG)
    begin
      seg_e_reg <= pwdata_in[`PPD_SEG_E_BIT];
      seg_d_reg <= pwdata_in[`PPD_SEG_D_BIT];
    end
  end

  // pin-level offset has no write decode, so writes are lost
  // ----------------------------------------------------------------
  // per-pin logic
  // ----------------------------------------------------------------
  wire [WIDTH-1:0] level_e;
  wire [WIDTH-1:0] pull_e;
  wire [WIDTH-1:0] pull_d;
  wire             gio_e = mode7 | (mode46 & ~bus16_in);
  // pull-ups blocked in hardware standby; reset clears the outputs
  wire             pull_ok_e = ~hw_standby_in & gio_e;
  wire             pull_ok_d = ~hw_standby_in & mode7;

  // one pin cell per bit for each port
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      ppd_pin_bit u_e
      (
        .dir_in     (pin_direction_e_reg[i]),
        .latch_in   (output_latch_e_reg[i]),
        .pin_in     (pin_e_in[i]),
        .pull_in    (pullup_control_e_reg[i]),
        .gio_in     (1'b1),
        .pull_ok_in (pull_ok_e),
        .seg_in     (seg_e_reg),
        .read_out   (level_e[i]),
        .pull_out   (pull_e[i])
      );
      ppd_pin_bit u_d
      (
        .dir_in     (pin_direction_d_reg[i]),
        .latch_in   (1'b0),
        .pin_in     (pin_d_in[i]),
        .pull_in    (pullup_control_d_reg[i]),
        .gio_in     (1'b1),
        .pull_ok_in (pull_ok_d),
        .seg_in     (seg_d_reg),
        .read_out   (),
        .pull_out   (pull_d[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin drive, registered
  // ----------------------------------------------------------------

  // pull-up gates; reset holds every pull-up off
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pull_e_out <= `PPD_RST_BYTE;
      pull_d_out <= `PPD_RST_BYTE;
    end
    else
    begin
      pull_e_out <= pull_e;
      pull_d_out <= pull_d;
    end
  end

  // direction copies for the pad ring
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pin_dir_d_out <= `PPD_RST_BYTE;
      pin_dir_f_out <= `PPD_RST_BYTE;
    end
    else
    begin
      pin_dir_d_out <= pin_direction_d_reg;
      pin_dir_f_out <= pin_direction_f_reg;
    end
  end

  // low data byte as seen on the pins, for the bus unit
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      low_data_byte_lines_out <= `PPD_RST_BYTE;
    else
      low_data_byte_lines_out <= pin_e_in;
  end

  // port e pin owner: segment unit, then bus unit, then the latch
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pin_e_out    <= `PPD_RST_BYTE;
      pin_e_oe_out <= `PPD_RST_BYTE;
    end
    else if (seg_e_reg)
    begin
      pin_e_out    <= seg_drive_in;
      pin_e_oe_out <= {WIDTH{1'b1}};
    end
    else if (!gio_e)
    begin
      pin_e_out    <= data_bus_out_in;
      pin_e_oe_out <= {WIDTH{data_bus_oe_in}};
    end
    else
    begin
      pin_e_out    <= output_latch_e_reg;
      pin_e_oe_out <= pin_direction_e_reg;
    end
  end

  // clock-out pin: driven only while port f bit 7 selects it
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      clock_out_pin_out <= 1'b0;
      clock_out_oe_out  <= 1'b0;
    end
    else
    begin
      clock_out_oe_out  <= pin_direction_f_reg[`PPD_F_CLK_BIT];
      clock_out_pin_out <= pin_direction_f_reg[`PPD_F_CLK_BIT] &
                           sys_clock_en_in;
    end
  end

  // ----------------------------------------------------------------
  // apb read path, data set up in the setup cycle
  // ----------------------------------------------------------------
  // upper bits read zero; write-only registers give a fixed word
  reg [31:0] rdata_next;
  always @*
  begin
    rdata_next = `PPD_ZERO_WORD;
    case (addr)
      `PPD_OFS_DIR_E:   rdata_next = `PPD_UNDEF_WORD;
      `PPD_OFS_LATCH_E: rdata_next[WIDTH-1:0] = output_latch_e_reg;
      `PPD_OFS_LEVEL_E: rdata_next[WIDTH-1:0] = level_e;
      `PPD_OFS_PULL_E:  rdata_next[WIDTH-1:0] = pullup_control_e_reg;
      `PPD_OFS_DIR_D:   rdata_next = `PPD_UNDEF_WORD;
      `PPD_OFS_PULL_D:  rdata_next[WIDTH-1:0] = pullup_control_d_reg;
      `PPD_OFS_DIR_F:   rdata_next = `PPD_UNDEF_WORD;
      `PPD_OFS_CTRL:    rdata_next[`PPD_CTRL_RD_BIT] = gio_e;
      `PPD_OFS_SEG:
      begin
        rdata_next[`PPD_SEG_E_BIT] = seg_e_reg;
        rdata_next[`PPD_SEG_D_BIT] = seg_d_reg;
      end
      default:          rdata_next = `PPD_ZERO_WORD;
    endcase
  end

  // ready high in the access cycle; unmapped reads return zero
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      prdata_out  <= `PPD_ZERO_WORD;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= 1'b0;
      if (setup_rd)
        prdata_out <= rdata_next;
    end
  end
endmodule // ppd_port_top
`default_nettype wire

//--- ppd_port_assertions.sv
// Purpose: concurrent checks on the port block pins
// Assumes: outputs are registered one cycle after their cause
// Notes:   bound to ppd_port_top
`timescale 1ns/1ps
`default_nettype none
module ppd_port_assertions
#(
  parameter WIDTH = 8
)
(
  input wire logic             sys_clk_in,
  input wire logic             arst_n_in,
  input wire logic [2:0]       mode_in,
  input wire logic             bus16_in,
  input wire logic             hw_standby_in,
  input wire logic [WIDTH-1:0] pin_e_in,
  input wire logic [WIDTH-1:0] pin_e_oe_out,
  input wire logic [WIDTH-1:0] pull_e_out,
  input wire logic [WIDTH-1:0] pull_d_out,
  input wire logic [WIDTH-1:0] low_data_byte_lines_out,
  input wire logic [WIDTH-1:0] pin_dir_d_out,
  input wire logic [7:0]       pin_dir_f_out,
  input wire logic             clock_out_oe_out,
  input wire logic             clock_out_pin_out
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  // modes 4 to 6
  wire m46 = (mode_in >= 3'h4) && (mode_in <= 3'h6);
  sequence s_release;
    $rose(arst_n_in);
  endsequence
  sequence s_f_loaded;
    ##3 pin_dir_f_out[7] == m46;
  endsequence
  a_f_rst_value: assert property (s_release |-> s_f_loaded)
    else $error("port f bit 7 reset value wrong");
  a_pull_stby_off: assert property (hw_standby_in |=>
    pull_e_out == 8'h00 && pull_d_out == 8'h00)
    else $error("pull-up on in standby");
  a_pull_bus16_off: assert property (m46 && bus16_in |=>
    pull_e_out == 8'h00) else $error("pull-up on with wide bus");
  a_pull_d_mode: assert property (mode_in != 3'h7 |=>
    pull_d_out == 8'h00) else $error("port d pull-up outside mode 7");
  a_pull_e_input: assert property (
    (pull_e_out & pin_e_oe_out) == 8'h00) else $error("pull on output");
  a_pull_d_input: assert property (
    (pull_d_out & pin_dir_d_out) == 8'h00) else $error("pull on output");
  a_clk_out_dir: assert property (
    clock_out_oe_out == pin_dir_f_out[7]) else $error("clock out enable");
  a_clk_pin_idle: assert property (
    !clock_out_oe_out |-> !clock_out_pin_out) else $error("clock pin driven");
  a_f_reserved: assert property (
    pin_dir_f_out[1] == 1'b0) else $error("reserved f bit set");
  a_data_byte_in: assert property (m46 && bus16_in |=>
    low_data_byte_lines_out == $past(pin_e_in))
    else $error("low data byte not captured");
endmodule // ppd_port_assertions
bind ppd_port_top ppd_port_assertions #(.WIDTH(WIDTH)) u_chk
(
  .sys_clk_in, .arst_n_in, .mode_in, .bus16_in, .hw_standby_in,
  .pin_e_in, .pin_e_oe_out, .pull_e_out, .pull_d_out,
  .low_data_byte_lines_out, .pin_dir_d_out, .pin_dir_f_out,
  .clock_out_oe_out, .clock_out_pin_out
);
`default_nettype wire

//--- ppd_pins_model.sv
// Purpose: board model of eight port pins
// Assumes: board drives the pins that en_in selects
// Notes:   a floating pin without pull-up shows its inverted last level
`timescale 1ns/1ps
`default_nettype none
module ppd_pins_model
(
  input  wire logic       clk_in,
  input  wire logic [7:0] drv_in,
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] pull_in,
  input  wire logic [7:0] ext_in,
  input  wire logic [7:0] en_in,
  output logic      [7:0] pin_out
);
  logic [7:0] last_reg = 8'h00;
  // wire level: device, then board, then pull-up, else drifting
  assign pin_out = (oe_in & drv_in) | (~oe_in & en_in & ext_in)
                 | (~oe_in & ~en_in & (pull_in | ~last_reg));
  // remember the level for the drifting case
  always @(posedge clk_in) last_reg <= pin_out;
endmodule // ppd_pins_model
`default_nettype wire

//--- tb_top.sv
// Purpose: self-checking bench for the port block
// Assumes: zero wait apb slave, outputs one cycle after cause
// Notes:   register traffic through one apb task
`timescale 1ns/1ps
`default_nettype none
`include "ppd_defines.vh"
module tb_top;
  logic        sys_clk_in, arst_n_in, psel, pen, pwr, pready;
  logic        b16, stby, dboe, ck_en, ck_o, ck_oe, slv, sq;
  logic [2:0]  mode;
  logic [7:0]  paddr, ext_e, en, seg, dbo, pe, peoe, pulle, pulld;
  logic [7:0]  ldb, dird, dirf, pin_e, pin_d;
  logic [31:0] pwdata, prdata, q;
  int          num_errors = 0;
  int          n_checks = 0;
  ppd_port_top DUT (.sys_clk_in, .arst_n_in, .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(slv), .mode_in(mode), .bus16_in(b16),
    .hw_standby_in(stby), .pin_e_in(pin_e), .pin_d_in(pin_d),
    .data_bus_out_in(dbo), .data_bus_oe_in(dboe), .seg_drive_in(seg),
    .sys_clock_en_in(ck_en), .pin_e_out(pe), .pin_e_oe_out(peoe),
    .pull_e_out(pulle), .pull_d_out(pulld),
    .low_data_byte_lines_out(ldb), .pin_dir_d_out(dird),
    .pin_dir_f_out(dirf), .clock_out_pin_out(ck_o),
    .clock_out_oe_out(ck_oe));
  ppd_pins_model u_pe (.clk_in(sys_clk_in), .drv_in(pe), .oe_in(peoe),
    .pull_in(pulle), .ext_in(ext_e), .en_in(en), .pin_out(pin_e));
  ppd_pins_model u_pd (.clk_in(sys_clk_in), .drv_in(8'h00),
    .oe_in(dird), .pull_in(pulld), .ext_in(8'h69), .en_in(en),
    .pin_out(pin_d));
  // clock
  initial
  begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  // compare and count
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer, read data into q
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    pen <= 1'b1;
    do @(posedge sys_clk_in); while (pready !== 1'b1);
    q = prdata;
    sq = slv;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task settle;
    repeat (3) @(posedge sys_clk_in);
  endtask
  task results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (4000) @(posedge sys_clk_in);
    num_errors++;
    results;
  end
  // main sequence
  initial
  begin
    {arst_n_in, psel, pen, pwr, b16, stby, dboe} = 7'h00;
    {paddr, pwdata, mode, ck_en} = {8'h00, 32'h0, 3'h7, 1'b1};
    {ext_e, en, seg, dbo} = 32'h3cff5a96;
    repeat (12) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    chk("dir f", dirf, 8'h00);
    chk("oe e", peoe, 8'h00);
    rd(`PPD_OFS_LATCH_E, 32'h0, "latch");
    rd(`PPD_OFS_PULL_E, 32'h0, "pull e rd");
    rd(`PPD_OFS_DIR_E, `PPD_UNDEF_WORD, "dir e rd");
    rd(`PPD_OFS_DIR_F, `PPD_UNDEF_WORD, "dir f rd");
    rd(8'h30, 32'h0, "unmapped");
    apb(1'b1, `PPD_OFS_DIR_E, 32'h0f);
    apb(1'b1, `PPD_OFS_LATCH_E, 32'hffffffa5);
    settle;
    chk("oe e", peoe, 8'h0f);
    chk("drive e", pe & 8'h0f, 8'h05);
    rd(`PPD_OFS_LEVEL_E, 32'h35, "level");
    apb(1'b1, `PPD_OFS_LEVEL_E, 32'hff);
    chk("slverr", sq, 32'h0);
    rd(`PPD_OFS_LEVEL_E, 32'h35, "level");
    rd(`PPD_OFS_LATCH_E, 32'ha5, "latch");
    apb(1'b1, `PPD_OFS_PULL_E, 32'hff);
    apb(1'b1, `PPD_OFS_DIR_D, 32'h03);
    apb(1'b1, `PPD_OFS_PULL_D, 32'hff);
    settle;
    chk("pull e", pulle, 8'hf0);
    chk("pull d", pulld, 8'hfc);
    en <= 8'h00;
    settle;
    rd(`PPD_OFS_LEVEL_E, 32'hf5, "level pulled");
    en <= 8'hff;
    stby <= 1'b1;
    settle;
    chk("pull e", pulle | pulld, 8'h00);
    stby <= 1'b0;
    mode <= 3'h4;
    settle;
    chk("pull e", pulle, 8'hf0);
    chk("pull d", pulld, 8'h00);
    b16 <= 1'b1;
    dboe <= 1'b1;
    settle;
    chk("pull e", pulle, 8'h00);
    chk("bus e", {pe, peoe}, 16'h96ff);
    rd(`PPD_OFS_CTRL, 32'h0, "ctrl");
    dboe <= 1'b0;
    settle;
    chk("data in", ldb, 8'h3c);
    mode <= 3'h7;
    b16 <= 1'b0;
    apb(1'b1, `PPD_OFS_SEG, 32'h3);
    settle;
    chk("seg e", {pe, pulle}, 16'h5a00);
    chk("seg d", pulld, 8'h00);
    rd(`PPD_OFS_SEG, 32'h3, "seg rd");
    rd(`PPD_OFS_CTRL, 32'h1, "ctrl");
    apb(1'b1, `PPD_OFS_SEG, 32'h0);
    apb(1'b1, `PPD_OFS_DIR_F, 32'hff);
    settle;
    chk("dir f", dirf, 8'hfd);
    chk("clk out", {ck_oe, ck_o}, 2'h3);
    ck_en <= 1'b0;
    settle;
    chk("clk out", {ck_oe, ck_o}, 2'h2);
    ck_en <= 1'b1;
    apb(1'b1, `PPD_OFS_DIR_F, 32'h0);
    settle;
    chk("dir f", {dirf, ck_oe}, 9'h000);
    mode <= 3'h4;
    arst_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    chk("dir f", dirf, 8'h80);
    chk("oe e", peoe, 8'h00);
    rd(`PPD_OFS_LATCH_E, 32'h0, "latch");
    results;
  end
endmodule // tb_top
`default_nettype wire
